// *** verilog/gpa_port.sv ***
// Behaviour
// - The direction register has one bit per pin, where 1 makes the pin an output and 0 an input.
// - The direction register cannot be read back and reads as all ones.
// - Reset or hardware standby loads direction 00 in mode 1 and 80 in mode 3.
// - Software standby leaves both registers exactly as they were written.
// - In software standby every output pin keeps driving its present level, except in a cycle that writes FFD1 or FFD3.
// - The data register is eight readable and writable bits of output data.
// - Reading the port returns the data-register bit for each output pin.
// - Reading the port returns the sampled pin level for each input pin.
// - Reset or hardware standby clears the data register to 00 in every mode.
// - Direction decodes at FFD1 and data at FFD3 on the low 16 address bits.
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
`include "gpa_cfg.svh"

module gpa_port
  import gpa_pkg::*;
(
  // Clock, reset and enable
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_ce,
  // Operating state
  input  wire logic       i_mode3,
  input  wire logic       i_hw_standby,
  input  wire logic       i_sw_standby,
  // Register port
  input  wire logic [15:0] i_addr,
  input  wire gpa_byte_t  i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output      gpa_byte_t  o_rdata,
  // Port pins
  input  wire gpa_byte_t  i_pin,
  output      gpa_byte_t  o_pin,
  output      gpa_byte_t  o_pin_oe
);

  // Registered state and the value it takes at the next enabled edge.
  gpa_state_t     st_reg;
  gpa_state_t     st_next;

  // Pin levels after the two-stage synchroniser.
  gpa_byte_t      pin_sync;

  // Address decode on the low 16 bits.
  logic           hit_dir;
  logic           hit_data;
  logic           hit_none;

  // Register strobes, qualified by the loading cycle.
  logic           run;
  logic           wr_dir;
  logic           wr_data;
  logic           rd_dir;
  logic           rd_data;
  logic           rd_none;

  // Software standby freezes the pin drive.
  logic           hold_pins;

  // Per-pin next values, one lane per pin.
  wire gpa_byte_t dir_lane;
  wire gpa_byte_t data_lane;
  wire gpa_byte_t oe_lane;
  wire gpa_byte_t out_lane;
  wire gpa_byte_t port_view;

  // Values loaded at the first enabled edge after reset or hardware standby.
  gpa_byte_t      dir_init;
  gpa_byte_t      data_init;

  // Read data for the cycle after the read strobe.
  gpa_byte_t      rdata_sel;

  // Nothing but the second stage reaches the read path.
  gpa_pin_sync u_sync (
    .i_clk  (i_clk),
    .i_rst  (i_rst),
    .i_ce   (i_ce),
    .i_pin  (i_pin),
    .o_sync (pin_sync)
  );

  always_comb begin
    hit_dir  = 1'b0;
    hit_data = 1'b0;
    case (i_addr)
      `GPA_ADDR_DIR: begin
        hit_dir = 1'b1;
      end
      `GPA_ADDR_DATA: begin
        hit_data = 1'b1;
      end
      default: begin
        hit_dir  = 1'b0;
        hit_data = 1'b0;
      end
    endcase
  end

  assign hit_none = !hit_dir && !hit_data;

  // Requests in the loading cycle after release are dropped while the strap is taken.
  assign run     = st_reg.init_done;
  assign wr_dir  = run && i_wr && hit_dir;
  assign wr_data = run && i_wr && hit_data;
  assign rd_dir  = run && i_rd && hit_dir;
  assign rd_data = run && i_rd && hit_data;
  assign rd_none = run && i_rd && hit_none;

  // A write in the same cycle still lands, so standby cannot swallow the last update.
  assign hold_pins = run && i_sw_standby && !wr_dir && !wr_data;

  genvar gi;
  generate
    for (gi = 0; gi < `GPA_LANES; gi++) begin : g_lane
      logic dir_bit;
      logic data_bit;
      logic oe_bit;
      logic out_bit;
      logic view_bit;

      // A write replaces the stored bit; otherwise it holds, in software standby too.
      always_comb begin
        if (wr_dir) begin
          dir_bit = i_wdata[gi];
        end else begin
          dir_bit = st_reg.dir[gi];
        end
      end

      always_comb begin
        if (wr_data) begin
          data_bit = i_wdata[gi];
        end else begin
          data_bit = st_reg.data[gi];
        end
      end

      // An input pin is not driven and its drive level is forced low.
      always_comb begin
        if (hold_pins) begin
          oe_bit  = st_reg.pin_oe[gi];
          out_bit = st_reg.pin_out[gi];
        end else begin
          oe_bit  = dir_bit;
          out_bit = data_bit & dir_bit;
        end
      end

      // Output pins read back the stored bit, so a loaded pin cannot change the answer.
      always_comb begin
        if (st_reg.dir[gi]) begin
          view_bit = st_reg.data[gi];
        end else begin
          view_bit = pin_sync[gi];
        end
      end

      assign dir_lane[gi]  = dir_bit;
      assign data_lane[gi] = data_bit;
      assign oe_lane[gi]   = oe_bit;
      assign out_lane[gi]  = out_bit;
      assign port_view[gi] = view_bit;
    end
  endgenerate

  // Mode is a strap, so the mode-dependent direction is taken in a clocked step after release.
  assign dir_init  = i_mode3 ? `GPA_DIR_RST_MODE3 : `GPA_DIR_RST_MODE1;
  assign data_init = `GPA_DATA_RST;

  // Unmapped reads answer zero rather than leaving the last value on the bus.
  always_comb begin
    rdata_sel = `GPA_READ_ZERO;
    case (1'b1)
      rd_dir: begin
        rdata_sel = `GPA_READ_ONES;
      end
      rd_data: begin
        rdata_sel = port_view;
      end
      rd_none: begin
        rdata_sel = `GPA_READ_ZERO;
      end
      default: begin
        rdata_sel = `GPA_READ_ZERO;
      end
    endcase
  end

  always_comb begin
    st_next       = st_reg;
    st_next.rdata = rdata_sel;
    if (!st_reg.init_done) begin
      st_next.dir       = dir_init;
      st_next.data      = data_init;
      st_next.pin_oe    = dir_init;
      st_next.pin_out   = data_init & dir_init;
      st_next.init_done = 1'b1;
    end else begin
      st_next.dir     = dir_lane;
      st_next.data    = data_lane;
      st_next.pin_oe  = oe_lane;
      st_next.pin_out = out_lane;
    end
  end

  // Hardware standby has the same effect as reset on st_reg; only reset clears the pin synchroniser.
  always_ff @(posedge i_clk) begin
    if (i_rst || i_hw_standby) begin
      st_reg <= '0;
    end else if (i_ce) begin
      st_reg <= st_next;
    end
  end

  assign o_rdata  = st_reg.rdata;
  assign o_pin    = st_reg.pin_out;
  assign o_pin_oe = st_reg.pin_oe;

endmodule : gpa_port

// *** verilog/gpa_cfg.svh ***
`ifndef GPA_CFG_SVH
`define GPA_CFG_SVH

`define GPA_ADDR_DIR      16'hffd1
`define GPA_ADDR_DATA     16'hffd3
`define GPA_DIR_RST_MODE1 8'h00
`define GPA_DIR_RST_MODE3 8'h80
`define GPA_DATA_RST      8'h00
`define GPA_READ_ONES     8'hff
`define GPA_READ_ZERO     8'h00
`define GPA_LANES         8

`endif

// *** verilog/gpa_pkg.sv ***
package gpa_pkg;
  typedef logic [7:0]  gpa_byte_t;
  typedef logic [15:0] gpa_addr_t;

  typedef struct packed {
    gpa_byte_t  dir;
    gpa_byte_t  data;
    gpa_byte_t  rdata;
    gpa_byte_t  pin_out;
    gpa_byte_t  pin_oe;
    logic       init_done;
  } gpa_state_t;

  typedef struct packed {
    gpa_byte_t  meta;
    gpa_byte_t  sync;
  } gpa_sync_state_t;
endpackage : gpa_pkg

// *** verilog/gpa_pin_sync.sv ***
`timescale 1ns/1ps
`include "gpa_cfg.svh"

// Two-stage synchroniser for the port pin levels, one lane per pin.
module gpa_pin_sync
  import gpa_pkg::*;
(
  // Clock and control
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_ce,
  // Pin levels
  input  wire gpa_byte_t  i_pin,
  output      gpa_byte_t  o_sync
);

  gpa_sync_state_t s_reg;
  gpa_sync_state_t s_next;

  always_comb begin
    s_next = s_reg;
    if (i_ce) begin
      s_next.meta = i_pin;
      s_next.sync = s_reg.meta;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_sync = s_reg.sync;

endmodule : gpa_pin_sync

// *** testbench/gpa_port_props.sv ***
`timescale 1ns/1ps
module gpa_port_props import gpa_pkg::*; (
  input logic i_clk, i_rst, i_ce, i_mode3, i_hw_standby, i_sw_standby, i_wr, i_rd,
  input logic [15:0] i_addr,
  input gpa_byte_t i_wdata, i_pin, o_rdata, o_pin, o_pin_oe);
  wire r = i_rst | i_hw_standby;
  wire d = i_addr == 16'hffd1;
  wire p = i_addr == 16'hffd3;
  default clocking @(posedge i_clk); endclocking
  default disable iff (r || !i_ce);
  a_dir_ones: assert property (i_rd && d |=> o_rdata == 8'hff) else $error("dir");
  a_out_read: assert property (i_rd && p |=> !((o_rdata ^ o_pin) & o_pin_oe))
    else $error("out");
  a_in_read: assert property (i_rd && p && $stable(i_pin) && $past(i_pin, 2) == i_pin
    |=> !((o_rdata ^ $past(i_pin)) & ~o_pin_oe)) else $error("in");
  a_dir_oe: assert property (i_wr && d |=> o_pin_oe == $past(i_wdata))
    else $error("oe");
  a_data_pin: assert property (i_wr && p |=> o_pin == ($past(i_wdata) & o_pin_oe))
    else $error("pin");
  a_bad_addr: assert property (i_rd && !d && !p |=> o_rdata == 8'h00) else $error("map");
  a_sw_hold: assert property (i_sw_standby && !i_wr && !$past(r)
    |=> $stable(o_pin) && $stable(o_pin_oe)) else $error("hold");
  a_reset_load: assert property ($fell(r) |=> o_pin == 8'h00
    && o_pin_oe == ($past(i_mode3) ? 8'h80 : 8'h00)) else $error("reset");
  cover property (i_rd && p);
  cover property ($fell(r));
  cover property (i_sw_standby && i_rd);
endmodule : gpa_port_props
bind gpa_port gpa_port_props u_props (.*);

// *** testbench/gpa_pin_model.sv ***
`timescale 1ns/1ps
// A driven pin shows the port's own drive; an input pin shows the outside level.
module gpa_pin_model import gpa_pkg::*; (
  input gpa_byte_t i_oe, i_out, i_ext,
  output gpa_byte_t o_level);
  assign o_level = i_oe & i_out | ~i_oe & i_ext;
endmodule : gpa_pin_model

// *** testbench/tb_top.sv ***
`timescale 1ns/1ps
module tb_top
  import gpa_pkg::*;
();
  logic i_clk = 0, i_rst = 1, i_ce = 1, i_mode3 = 1, i_wr = 0, i_rd = 0;
  logic i_hw_standby = 0, i_sw_standby = 0;
  gpa_addr_t i_addr = 0;
  gpa_byte_t i_wdata = 0, x = 8'ha5, i_pin, o_rdata, o_pin, o_pin_oe;
  int bad_count = 0, tests_run = 0;
  gpa_port dut (.*);
  gpa_pin_model pm (.i_oe(o_pin_oe), .i_out(o_pin), .i_ext(x), .o_level(i_pin));
  initial forever #2.5 i_clk = ~i_clk;
  initial #9000 summarize(1);
  // Reads drop their strobe at once so no call assigns it twice in one step.
  task automatic io(logic w, gpa_addr_t a, gpa_byte_t v);
    {i_addr, i_wdata, i_wr, i_rd} <= {a, v, w, !w};
    @(posedge i_clk);
    if (!w) begin
      i_rd <= 1'h0;
      #1 tests_run++;
      if (o_rdata !== v) begin
        bad_count++;
        $display("ERROR rdata %h exp %h got %h", a, v, o_rdata);
      end
      @(posedge i_clk);
    end
  endtask : io
  // Pin outputs are looked at 1 ns after the edge, once they have settled.
  task automatic pin_chk(gpa_byte_t eo, gpa_byte_t ep);
    #1 tests_run += 2;
    if (o_pin_oe !== eo) begin
      bad_count++;
      $display("ERROR o_pin_oe exp %h got %h", eo, o_pin_oe);
    end
    if (o_pin !== ep) begin
      bad_count++;
      $display("ERROR o_pin exp %h got %h", ep, o_pin);
    end
    @(posedge i_clk);
  endtask : pin_chk
  task automatic summarize(int f);
    bad_count += f;
    $display("%0d checks %0d mismatches", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : summarize
  initial begin
    repeat (16) @(posedge i_clk);
    i_rst <= 1'h0;
    repeat (3) @(posedge i_clk);
    pin_chk(8'h80, 8'h00);
    io(0, 16'hffd1, 8'hff);
    io(0, 16'hffd3, 8'h25);
    io(1, 16'hffd1, 8'h0f);
    io(1, 16'hffd3, 8'h5a);
    io(1, 16'hffd5, 8'hff);
    io(0, 16'hffd3, 8'haa);
    pin_chk(8'h0f, 8'h0a);
    io(0, 16'hffd2, 8'h00);
    {x, i_sw_standby} <= {8'hc3, 1'h1};
    repeat (4) @(posedge i_clk);
    io(0, 16'hffd3, 8'hca);
    pin_chk(8'h0f, 8'h0a);
    $display("test 1 done");
    {i_mode3, i_hw_standby, i_sw_standby} <= 3'h2;
    @(posedge i_clk);
    i_hw_standby <= 1'h0;
    repeat (3) @(posedge i_clk);
    io(0, 16'hffd3, 8'hc3);
    pin_chk(8'h00, 8'h00);
    io(1, 16'hffd1, 8'hff);
    io(0, 16'hffd3, 8'h00);
    $display("test 2 done");
    summarize(0);
  end
endmodule : tb_top
